// file: rtl/cfim_charger_fault_irq.sv
`timescale 1ns/10ps
`include "cfim_map.svh"
module cfim_charger_fault_irq
  import cfim_pkg::*;
#(
  parameter int PULSE_CYC = `CFIM_IRQ_PULSE_CYC
) (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  // Register access from the serial front end (same clock)
  input  wire cfim_req_t regReq,
  output logic [7:0]     rdData,
  // Register reset command, one-cycle pulse
  input  wire logic      regResetCmd,
  // Raw event levels from the analog side (asynchronous)
  input  wire cfim_ev_t  evRaw,
  // Interrupt pulse to the host
  output logic           irqPulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  cfim_ev_t   ev;
  cfim_ev_t   evPrev_q;
  logic       evValid_q;
  logic [1:0] warmCnt_q;

  cfim_sync #(
    .WIDTH (CFIM_EV_W)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (evRaw),
    .syncOut (ev)
  );

  // Previous sample for edge detection. A level already high in reset only shows at the
  // synchroniser output two edges after release, so events wait until both the sample
  // and its history carry real pin levels; otherwise a false edge follows every reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      evPrev_q  <= '0;
      warmCnt_q <= 2'h0;
      evValid_q <= 1'b0;
    end
    else
    begin
      evPrev_q  <= ev;
      if (warmCnt_q != 2'h3)
        warmCnt_q <= warmCnt_q + 2'h1;
      evValid_q <= warmCnt_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection

  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction

  logic evShort, evOvervolt, evTshut;
  logic evIcl, evIvl, evWdog, evWeak, evPgood, evIn2, evIn1, evBusPres;
  logic evChg, evOpt, evBusState, evTreg, evBat, evUsb;

  // Flag faults and the limiting, watchdog, weak-source and die-thermal events on their rising edge; other status fields on any change
  always_comb
  begin
    evShort    = evValid_q & rose(ev.sysShort, evPrev_q.sysShort);
    evOvervolt = evValid_q & rose(ev.sysOvervolt, evPrev_q.sysOvervolt);
    evTshut    = evValid_q & rose(ev.thermalShutdown, evPrev_q.thermalShutdown);
    evIcl      = evValid_q & rose(ev.inputCurrentLimiting, evPrev_q.inputCurrentLimiting);
    evIvl      = evValid_q & rose(ev.inputVoltageLimiting, evPrev_q.inputVoltageLimiting);
    evWdog     = evValid_q & rose(ev.watchdogExpired, evPrev_q.watchdogExpired);
    evWeak     = evValid_q & rose(ev.weakSource, evPrev_q.weakSource);
    evPgood    = evValid_q & (ev.powerGood != evPrev_q.powerGood);
    evIn2      = evValid_q & (ev.secondInputPresent != evPrev_q.secondInputPresent);
    evIn1      = evValid_q & (ev.firstInputPresent != evPrev_q.firstInputPresent);
    evBusPres  = evValid_q & (ev.busInputPresent != evPrev_q.busInputPresent);
    evChg      = evValid_q & (ev.chargeState != evPrev_q.chargeState);
    evOpt      = evValid_q & (ev.currentOptimizer != evPrev_q.currentOptimizer);
    evBusState = evValid_q & (ev.busInputState != evPrev_q.busInputState);
    evTreg     = evValid_q & rose(ev.dieThermalRegulation, evPrev_q.dieThermalRegulation);
    evBat      = evValid_q & (ev.batteryPresent != evPrev_q.batteryPresent);
    evUsb      = evValid_q & (ev.usbDetectDone != evPrev_q.usbDetectDone);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flag register

  logic [7:0] faultFlags_q;
  logic       rdFlags;

  assign rdFlags = regReq.rdEn && regReq.addr == `CFIM_OFS_FAULT_FLAGS_ONE;

  // Sticky flags cleared by a read; a new event in the read cycle wins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      faultFlags_q <= `CFIM_RESET_VALUE;
    else
    begin
      if (rdFlags || regResetCmd)
        faultFlags_q <= `CFIM_RESET_VALUE;
      if (evShort)
        faultFlags_q[`CFIM_BIT_SYS_SHORT] <= 1'b1;
      if (evOvervolt)
        faultFlags_q[`CFIM_BIT_SYS_OVERVOLT] <= 1'b1;
      if (evTshut)
        faultFlags_q[`CFIM_BIT_THERMAL_SHUTDOWN] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask registers

  logic [7:0] maskZero_q;
  logic [7:0] maskOne_q;

  // Host writes only reach implemented bits; flags take no writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      maskZero_q <= `CFIM_RESET_VALUE;
      maskOne_q  <= `CFIM_RESET_VALUE;
    end
    else if (regResetCmd)
    begin
      maskZero_q <= `CFIM_RESET_VALUE;
      maskOne_q  <= `CFIM_RESET_VALUE;
    end
    else if (regReq.wrEn)
    begin
      if (regReq.addr == `CFIM_OFS_IRQ_MASK_ZERO)
        maskZero_q <= regReq.wrData & `CFIM_MASK_ZERO_USED;
      if (regReq.addr == `CFIM_OFS_IRQ_MASK_ONE)
        maskOne_q <= regReq.wrData & `CFIM_MASK_ONE_USED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdData <= 8'h00;
    else if (regReq.rdEn)
    begin
      case (regReq.addr)
        `CFIM_OFS_FAULT_FLAGS_ONE: rdData <= faultFlags_q & `CFIM_FLAG_ONE_USED;
        `CFIM_OFS_IRQ_MASK_ZERO:   rdData <= maskZero_q;
        `CFIM_OFS_IRQ_MASK_ONE:    rdData <= maskOne_q & `CFIM_MASK_ONE_USED;
        default:                   rdData <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating

  logic irqReq;

  // A mask only gates the pulse, never the flag
  always_comb
  begin
    irqReq = 1'b0;
    irqReq |= evShort | evOvervolt | evTshut;
    irqReq |= evIcl & ~maskZero_q[`CFIM_BIT_ICL_BLOCK];
    irqReq |= evIvl & ~maskZero_q[`CFIM_BIT_IVL_BLOCK];
    irqReq |= evWdog & ~maskZero_q[`CFIM_BIT_WDOG_BLOCK];
    irqReq |= evWeak & ~maskZero_q[`CFIM_BIT_WEAK_SRC_BLOCK];
    irqReq |= evPgood & ~maskZero_q[`CFIM_BIT_PGOOD_BLOCK];
    irqReq |= evIn2 & ~maskZero_q[`CFIM_BIT_IN2_PRES_BLOCK];
    irqReq |= evIn1 & ~maskZero_q[`CFIM_BIT_IN1_PRES_BLOCK];
    irqReq |= evBusPres & ~maskZero_q[`CFIM_BIT_BUS_PRES_BLOCK];
    irqReq |= evChg & ~maskOne_q[`CFIM_BIT_CHG_STATE_BLOCK];
    irqReq |= evOpt & ~maskOne_q[`CFIM_BIT_OPTIMIZER_BLOCK];
    irqReq |= evBusState & ~maskOne_q[`CFIM_BIT_BUS_STATE_BLOCK];
    irqReq |= evTreg & ~maskOne_q[`CFIM_BIT_DIE_DIE_THERMAL_REGULATION_BLOCK];
    irqReq |= evBat & ~maskOne_q[`CFIM_BIT_BAT_PRES_BLOCK];
    irqReq |= evUsb & ~maskOne_q[`CFIM_BIT_USB_DET_BLOCK];
  end

  cfim_pulse #(
    .PULSE_CYC (PULSE_CYC)
  ) u_pulse (
    .clk      (clk),
    .rst      (rst),
    .trigger  (irqReq),
    .irqPulse (irqPulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_short_flag;
    @(posedge clk) disable iff (rst) evShort |=> faultFlags_q[7];
  endproperty
  a_short_flag: assert property (p_short_flag) else $error("short flag not set");

  property p_ovp_flag;
    @(posedge clk) disable iff (rst) evOvervolt |=> faultFlags_q[6];
  endproperty
  a_ovp_flag: assert property (p_ovp_flag) else $error("overvoltage flag not set");

  property p_thermal_shutdown_event;
    @(posedge clk) disable iff (rst) evTshut |=> faultFlags_q[2];
  endproperty
  a_thermal_shutdown_event: assert property (p_thermal_shutdown_event) else $error("shutdown flag not set");

  property p_masks_reset;
    @(posedge clk) disable iff (rst) regResetCmd |=> (maskZero_q == 8'h00 && maskOne_q == 8'h00);
  endproperty
  a_masks_reset: assert property (p_masks_reset) else $error("masks not cleared");

  property p_icl_masked;
    @(posedge clk) disable iff (rst)
      (maskZero_q == 8'hff && maskOne_q == 8'hd7 && !evShort && !evOvervolt && !evTshut)
      |-> !irqReq;
  endproperty
  a_icl_masked: assert property (p_icl_masked) else $error("masked event raised irq");

  property p_icl_irq;
    @(posedge clk) disable iff (rst)
      (evIcl && !maskZero_q[7] && irqPulse == 1'b0 && u_pulse.state_q == CFIM_IDLE)
      |=> irqPulse;
  endproperty
  a_icl_irq: assert property (p_icl_irq) else $error("unmasked event gave no pulse");

  property p_pgood_irq;
    @(posedge clk) disable iff (rst)
      (evPgood && !maskZero_q[3] && u_pulse.state_q == CFIM_IDLE) |=> irqPulse;
  endproperty
  a_pgood_irq: assert property (p_pgood_irq) else $error("power good toggle no pulse");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      (faultFlags_q & 8'h3b) == 8'h00 && (maskOne_q & 8'h28) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_flag_sticky;
    @(posedge clk) disable iff (rst)
      (faultFlags_q[7] && !rdFlags && !regResetCmd) |=> faultFlags_q[7];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without read");

  // A host write aimed at the flags must leave them exactly as they were
  property p_flags_ro;
    @(posedge clk) disable iff (rst)
      (regReq.wrEn && regReq.addr == `CFIM_OFS_FAULT_FLAGS_ONE && !rdFlags && !regResetCmd
       && !evShort && !evOvervolt && !evTshut) |=> $stable(faultFlags_q);
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("flag register took a write");

  property p_mask1_wr;
    @(posedge clk) disable iff (rst)
      (regReq.wrEn && regReq.addr == `CFIM_OFS_IRQ_MASK_ONE && !regResetCmd)
      |=> maskOne_q == ($past(regReq.wrData) & `CFIM_MASK_ONE_USED);
  endproperty
  a_mask1_wr: assert property (p_mask1_wr) else $error("mask write lost");

  property p_rd_flags;
    @(posedge clk) disable iff (rst)
      rdFlags |=> rdData == ($past(faultFlags_q) & `CFIM_FLAG_ONE_USED);
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag read data wrong");

  // Faults have no mask in these registers, so they always reach the pulse
  property p_tshut_irq;
    @(posedge clk) disable iff (rst)
      (evTshut && u_pulse.state_q == CFIM_IDLE) |=> irqPulse;
  endproperty
  a_tshut_irq: assert property (p_tshut_irq) else $error("fault gave no pulse");

  property p_chg_irq;
    @(posedge clk) disable iff (rst)
      (evChg && !maskOne_q[7] && u_pulse.state_q == CFIM_IDLE) |=> irqPulse;
  endproperty
  a_chg_irq: assert property (p_chg_irq) else $error("charge change gave no pulse");

  property p_usb_irq;
    @(posedge clk) disable iff (rst)
      (evUsb && !maskOne_q[0] && u_pulse.state_q == CFIM_IDLE) |=> irqPulse;
  endproperty
  a_usb_irq: assert property (p_usb_irq) else $error("detect change gave no pulse");

endmodule

// file: rtl/cfim_map.svh
`ifndef CFIM_MAP_SVH
`define CFIM_MAP_SVH

// Register offsets on the serial register port
`define CFIM_OFS_FAULT_FLAGS_ONE   8'h27
`define CFIM_OFS_IRQ_MASK_ZERO     8'h28
`define CFIM_OFS_IRQ_MASK_ONE      8'h29

// Fault flag bit positions
`define CFIM_BIT_SYS_SHORT         7
`define CFIM_BIT_SYS_OVERVOLT      6
`define CFIM_BIT_THERMAL_SHUTDOWN  2

// Mask zero bit positions
`define CFIM_BIT_ICL_BLOCK         7
`define CFIM_BIT_IVL_BLOCK         6
`define CFIM_BIT_WDOG_BLOCK        5
`define CFIM_BIT_WEAK_SRC_BLOCK    4
`define CFIM_BIT_PGOOD_BLOCK       3
`define CFIM_BIT_IN2_PRES_BLOCK    2
`define CFIM_BIT_IN1_PRES_BLOCK    1
`define CFIM_BIT_BUS_PRES_BLOCK    0

// Mask one bit positions
`define CFIM_BIT_CHG_STATE_BLOCK   7
`define CFIM_BIT_OPTIMIZER_BLOCK   6
`define CFIM_BIT_BUS_STATE_BLOCK   4
`define CFIM_BIT_DIE_DIE_THERMAL_REGULATION_BLOCK    2
`define CFIM_BIT_BAT_PRES_BLOCK    1
`define CFIM_BIT_USB_DET_BLOCK     0

// Implemented bits and reset values
`define CFIM_FLAG_ONE_USED         8'hc4
`define CFIM_MASK_ZERO_USED        8'hff
`define CFIM_MASK_ONE_USED         8'hd7
`define CFIM_RESET_VALUE           8'h00

// Interrupt pulse length in ns, and in clock cycles at 125 MHz
`define CFIM_CLK_PERIOD_NS         8
`define CFIM_IRQ_PULSE_NS          256
`define CFIM_IRQ_PULSE_CYC         (`CFIM_IRQ_PULSE_NS / `CFIM_CLK_PERIOD_NS)

`endif

// file: rtl/cfim_pkg.sv
package cfim_pkg;

  // Register access request from the serial front end
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } cfim_req_t;

  // Raw fault and event levels from the analog and charger logic
  typedef struct packed {
    logic       sysShort;
    logic       sysOvervolt;
    logic       thermalShutdown;
    logic       inputCurrentLimiting;
    logic       inputVoltageLimiting;
    logic       watchdogExpired;
    logic       weakSource;
    logic       powerGood;
    logic       secondInputPresent;
    logic       firstInputPresent;
    logic       busInputPresent;
    logic [2:0] chargeState;
    logic [1:0] currentOptimizer;
    logic [3:0] busInputState;
    logic       dieThermalRegulation;
    logic       batteryPresent;
    logic       usbDetectDone;
  } cfim_ev_t;

  localparam int CFIM_EV_W = $bits(cfim_ev_t);

  // Interrupt pulse generator states
  typedef enum logic [1:0] {
    CFIM_IDLE  = 2'b00,
    CFIM_PULSE = 2'b01,
    CFIM_GAP   = 2'b10
  } cfim_state_t;

endpackage

// file: rtl/cfim_pulse.sv
`timescale 1ns/10ps
`include "cfim_map.svh"
// Stretches a request into a fixed-length interrupt pulse, with a gap after
module cfim_pulse
  import cfim_pkg::*;
#(
  parameter int PULSE_CYC = `CFIM_IRQ_PULSE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Request and pulse
  input  wire logic trigger,
  output logic      irqPulse
);

  cfim_state_t state_q;
  logic [15:0] count_q;
  logic        pend_q;

  // Requests arriving while busy are held in one pending bit, so several collapse into one later pulse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= CFIM_IDLE;
      count_q <= 16'h0000;
      pend_q  <= 1'b0;
    end
    else
    begin
      if (trigger && state_q != CFIM_IDLE)
        pend_q <= 1'b1;
      case (state_q)
        CFIM_IDLE:
          if (trigger || pend_q)
          begin
            state_q <= CFIM_PULSE;
            count_q <= 16'(PULSE_CYC - 1);
            pend_q  <= 1'b0;
          end
        CFIM_PULSE, CFIM_GAP:
          if (count_q == 16'h0000)
          begin
            state_q <= (state_q == CFIM_PULSE) ? CFIM_GAP : CFIM_IDLE;
            count_q <= 16'(PULSE_CYC - 1);
          end
          else
            count_q <= count_q - 16'h0001;
        default:
          state_q <= CFIM_IDLE;
      endcase
    end
  end

  assign irqPulse = (state_q == CFIM_PULSE);

endmodule

// file: rtl/cfim_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for a bundle of asynchronous levels
module cfim_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q  <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// file: test/cfim_charger_fault_irq_tb.sv
`timescale 1ns/10ps
`include "cfim_map.svh"
module cfim_charger_fault_irq_tb
  import cfim_pkg::*;
;
  // Short pulse keeps each event step brief
  localparam int PC = 4;
  // Event bit in the raw bundle, mask bit, for each maskable event
  localparam int EVB [14] = '{19, 18, 17, 16, 15, 14, 13, 12, 9, 7, 3, 2, 1, 0};
  localparam int MB  [14] = '{7, 6, 5, 4, 3, 2, 1, 0, 7, 6, 4, 2, 1, 0};
  // Fault bits in the raw bundle and the flag value each should leave
  localparam int FB  [3]  = '{22, 21, 20};
  localparam logic [7:0] FV [3] = '{8'h80, 8'h40, 8'h04};

  logic       clk;
  logic       rst;
  cfim_req_t  regReq;
  logic [7:0] rdData;
  logic       regResetCmd;
  cfim_ev_t   evRaw;
  logic       irqPulse;
  int         failCount;
  int         samplesChecked;
  logic [7:0] mAddr;
  int         base;

  //////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  initial clk = 1'b0;
  always #4 clk = ~clk;

  cfim_charger_fault_irq #(.PULSE_CYC(PC)) dut (
    .clk         (clk),
    .rst         (rst),
    .regReq      (regReq),
    .rdData      (rdData),
    .regResetCmd (regResetCmd),
    .evRaw       (evRaw),
    .irqPulse    (irqPulse)
  );

  cfim_host_model host (
    .clk      (clk),
    .rst      (rst),
    .regReq   (regReq),
    .rdData   (rdData),
    .irqPulse (irqPulse)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checking helpers
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    check($sformatf("register %h", a), exp, v);
  endtask

  // Raise one event, count pulses over pulse plus gap, then drop it and let it settle
  task automatic fire(input int b, input logic [7:0] exp);
    int n;
    n = host.irqCount;
    @(negedge clk);
    evRaw[b] = 1'b1;
    repeat (20) @(negedge clk);
    check($sformatf("pulses for event bit %0d", b), exp, 8'(host.irqCount - n));
    evRaw[b] = 1'b0;
    repeat (20) @(negedge clk);
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs about 1400 cycles, so 20000 means a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    failCount++;
    results();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    failCount      = 0;
    samplesChecked = 0;
    rst            = 1'b1;
    regResetCmd    = 1'b0;
    evRaw          = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    // Power-up values, unmapped place
    rdChk(8'h27, 8'h00);
    rdChk(8'h28, 8'h00);
    rdChk(8'h29, 8'h00);
    rdChk(8'h30, 8'h00);
    // Access kinds and reserved bits
    host.wr(8'h28, 8'hff);
    rdChk(8'h28, 8'hff);
    host.wr(8'h29, 8'hff);
    rdChk(8'h29, 8'hd7);
    host.wr(8'h27, 8'hff);
    rdChk(8'h27, 8'h00);
    // Register reset command clears both masks
    @(negedge clk);
    regResetCmd = 1'b1;
    @(negedge clk);
    regResetCmd = 1'b0;
    rdChk(8'h28, 8'h00);
    rdChk(8'h29, 8'h00);
    // Each event: a pulse while unmasked, none once its own mask bit is set
    for (int k = 0; k < 14; k++)
    begin
      mAddr = (k < 8) ? 8'h28 : 8'h29;
      fire(EVB[k], 8'h01);
      host.wr(mAddr, 8'(1 << MB[k]));
      fire(EVB[k], 8'h00);
      host.wr(mAddr, 8'h00);
    end
    check("pulse width", 8'(PC), 8'(host.pulseWidth));
    // Faults set their flag and still interrupt with every mask set; a read clears the flag
    host.wr(8'h28, 8'hff);
    host.wr(8'h29, 8'hff);
    for (int f = 0; f < 3; f++)
    begin
      base = host.irqCount;
      @(negedge clk);
      evRaw[FB[f]] = 1'b1;
      repeat (10) @(negedge clk);
      rdChk(8'h27, FV[f]);
      check("fault pulses", 8'h01, 8'(host.irqCount - base));
      evRaw[FB[f]] = 1'b0;
      repeat (10) @(negedge clk);
      rdChk(8'h27, 8'h00);
    end
    // Mid-run reset with a level already high: no false event after release, masks cleared
    @(negedge clk);
    rst       = 1'b1;
    evRaw[15] = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    check("pulses after reset", 8'h00, 8'(host.irqCount));
    rdChk(8'h28, 8'h00);
    rdChk(8'h29, 8'h00);
    // The same level now falling is a genuine toggle
    evRaw[15] = 1'b0;
    repeat (20) @(negedge clk);
    check("pulses after drop", 8'h01, 8'(host.irqCount));
    results();
  end
endmodule

// file: test/cfim_host_model.sv
`timescale 1ns/10ps
// Host stand-in: register cycles on the same-clock port and an interrupt pulse counter
module cfim_host_model
  import cfim_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  output cfim_req_t       regReq,
  input  wire logic [7:0] rdData,
  // Interrupt line
  input  wire logic       irqPulse
);
  int irqCount;
  int pulseWidth;
  int runLen;

  initial regReq = '0;

  //////////////////////////////////////////////////////////////////////////////
  // Count pulses by their rising edge, so a long pulse is still one interrupt
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irqCount   <= 0;
      pulseWidth <= 0;
      runLen     <= 0;
    end
    else if (irqPulse === 1'b1)
    begin
      runLen <= runLen + 1;
      if (runLen == 0)
        irqCount <= irqCount + 1;
    end
    else
    begin
      if (runLen != 0)
        pulseWidth <= runLen;
      runLen <= 0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write: strobe held across one rising edge; data line flipped once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq.wrEn   = 1'b1;
    regReq.addr   = a;
    regReq.wrData = d;
    @(negedge clk);
    regReq.wrEn   = 1'b0;
    regReq.wrData = ~d;
  endtask

  // Read: data is sampled a cycle and a half after the taking edge, where it is settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regReq.rdEn = 1'b1;
    regReq.addr = a;
    @(negedge clk);
    regReq.rdEn = 1'b0;
    @(negedge clk);
    d = rdData;
  endtask
endmodule
